// File: motion_event_interrupt_unit.sv
// motion event interrupt unit: latched event flags, enables and interrupt output
`timescale 1ns/1ps
module motion_event_interrupt_unit
	import motion_event_pkg::*;
#(
	parameter int POS_W = 32
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// register port from the serial interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// event sources, all on the system clock
	input wire logic target_reached_i,
	input wire logic [POS_W-1:0] pid_error_i,
	input wire logic [POS_W-1:0] pid_tolerance_i,
	input wire logic index_event_i,
	input wire logic stop_event_i,
	input wire logic [DRV_STATUS_W-1:0] driver_status_i,
	input wire logic ref_left_i,
	input wire logic ref_right_i,
	// position compare inputs
	input wire logic [POS_W-1:0] x_actual_i,
	input wire logic [POS_W-1:0] enc_x_i,
	input wire logic enc_select_i,
	input wire logic [POS_W-1:0] compare_value_i,
	input wire logic compare_wr_i,
	// outputs
	output logic position_compare_out_o,
	output logic int_n_o
);

	typedef struct packed {
		logic [EVENT_COUNT-1:0] enable;
		logic [EVENT_COUNT-1:0] pending;
		logic target_prev;
		logic deviation_prev;
		logic driver_prev;
		logic ref_left_prev;
		logic ref_right_prev;
		logic [DATA_W-1:0] rdata;
		logic irq_n;
	} event_state_s;

	localparam event_state_s STATE_RESET = '{
		enable: EVENT_ENABLE_RESET,
		pending: EVENT_PENDING_RESET,
		target_prev: 1'b0,
		deviation_prev: 1'b0,
		driver_prev: 1'b0,
		ref_left_prev: 1'b0,
		ref_right_prev: 1'b0,
		rdata: READ_DATA_RESET,
		irq_n: 1'b1
	};

	event_state_s state_reg;
	event_state_s state_next;
	logic [EVENT_COUNT-1:0] event_hit;
	logic [EVENT_COUNT-1:0] clear_mask;
	logic deviation_now;

	compare_link_if #(.POS_W(POS_W)) link ();

	// magnitude of a two's complement value; the most negative value stays
	// as its own bit pattern, which is still the largest magnitude
	function automatic logic [POS_W-1:0] magnitude(input logic [POS_W-1:0] v);
		magnitude = v[POS_W-1] ? (~v + {{(POS_W-1){1'b0}}, 1'b1}) : v;
	endfunction

	// ----------------------------------------------------------------
	// position compare stage
	// ----------------------------------------------------------------
	// encoder or ramp position feeds the comparator
	assign link.position = enc_select_i ? enc_x_i : x_actual_i;
	assign link.compare_value = compare_value_i;
	assign link.compare_wr = compare_wr_i;

	position_compare_unit #(.POS_W(POS_W)) u_compare (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.link(link)
	);

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	// level sources count on their rising edge so a held level flags once
	assign deviation_now = magnitude(pid_error_i) > pid_tolerance_i;

	always_comb begin
		event_hit = '0;
		event_hit[EV_TARGET] = target_reached_i && !state_reg.target_prev;
		event_hit[EV_DEVIATION] = deviation_now && !state_reg.deviation_prev;
		event_hit[EV_INDEX] = index_event_i;
		event_hit[EV_STOP] = stop_event_i;
		event_hit[EV_DRIVER] = driver_status_i[DRV_ERROR_BIT] && !state_reg.driver_prev;
		event_hit[EV_REF_LEFT] = ref_left_i && !state_reg.ref_left_prev;
		event_hit[EV_REF_RIGHT] = ref_right_i && !state_reg.ref_right_prev;
		event_hit[EV_COMPARE] = link.change;
	end

	// ----------------------------------------------------------------
	// register port and flag update
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		clear_mask = '0;
		state_next.target_prev = target_reached_i;
		state_next.deviation_prev = deviation_now;
		state_next.driver_prev = driver_status_i[DRV_ERROR_BIT];
		state_next.ref_left_prev = ref_left_i;
		state_next.ref_right_prev = ref_right_i;
		// writes: enable is write-only, pending is write-one-to-clear
		if (reg_wr_i && (reg_addr_i == EVENT_ENABLE_ADDR)) begin
			state_next.enable = reg_wdata_i[EVENT_COUNT-1:0];
		end else if (reg_wr_i && (reg_addr_i == EVENT_PENDING_ADDR)) begin
			clear_mask = reg_wdata_i[EVENT_COUNT-1:0];
		end
		// reads: only pending is readable, anything else reads zero
		if (reg_rd_i && (reg_addr_i == EVENT_PENDING_ADDR)) begin
			state_next.rdata = {{(DATA_W-EVENT_COUNT){1'b0}}, state_reg.pending};
		end else if (reg_rd_i) begin
			state_next.rdata = '0;
		end
		// a new event beats a clear in the same cycle so it is never lost
		state_next.pending = (state_reg.pending & ~clear_mask) |
			(event_hit & state_reg.enable);
		state_next.irq_n = ~|state_next.pending;
	end

	// state register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_o = state_reg.rdata;
	assign int_n_o = state_reg.irq_n;
	assign position_compare_out_o = link.out_level;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence pending_clear_write(int b);
		reg_wr_i && (reg_addr_i == EVENT_PENDING_ADDR) && reg_wdata_i[b];
	endsequence

	sequence pending_read;
		reg_rd_i && (reg_addr_i == EVENT_PENDING_ADDR);
	endsequence

	target_flag_a: assert property (
		$rose(target_reached_i) && state_reg.enable[EV_TARGET]
		|=> state_reg.pending[EV_TARGET] && !int_n_o)
	else $error("target event not latched");

	deviation_flag_a: assert property (
		deviation_now && !state_reg.deviation_prev && state_reg.enable[EV_DEVIATION]
		|=> state_reg.pending[EV_DEVIATION])
	else $error("deviation event not latched");

	index_flag_a: assert property (
		index_event_i && state_reg.enable[EV_INDEX] |=> state_reg.pending[EV_INDEX])
	else $error("index event not latched");

	stop_flag_a: assert property (
		stop_event_i && state_reg.enable[EV_STOP] |=> state_reg.pending[EV_STOP])
	else $error("stop event not latched");

	driver_flag_a: assert property (
		$rose(driver_status_i[DRV_ERROR_BIT]) && state_reg.enable[EV_DRIVER]
		|=> state_reg.pending[EV_DRIVER])
	else $error("driver error not latched");

	ref_switch_flag_a: assert property (
		($rose(ref_left_i) && state_reg.enable[EV_REF_LEFT] |=> state_reg.pending[EV_REF_LEFT]))
	else $error("left reference event not latched");

	ref_right_flag_a: assert property (
		$rose(ref_right_i) && state_reg.enable[EV_REF_RIGHT] |=> state_reg.pending[EV_REF_RIGHT])
	else $error("right reference event not latched");

	compare_flag_a: assert property (
		link.change && state_reg.enable[EV_COMPARE]
		|=> state_reg.pending[EV_COMPARE] ##1 state_reg.pending[EV_COMPARE] || $past(reg_wr_i))
	else $error("compare change not latched");

	pending_readback_a: assert property (
		pending_read |=> reg_rdata_o == {{(DATA_W-EVENT_COUNT){1'b0}}, $past(state_reg.pending)})
	else $error("pending read returned wrong value");

	clear_one_a: assert property (
		pending_clear_write(EV_STOP)
		|=> !state_reg.pending[EV_STOP] || $past(stop_event_i && state_reg.enable[EV_STOP]))
	else $error("write one did not clear pending bit");

	clear_keep_a: assert property (
		reg_wr_i && (reg_addr_i == EVENT_PENDING_ADDR) && state_reg.pending[EV_STOP] &&
		!reg_wdata_i[EV_STOP] |=> state_reg.pending[EV_STOP])
	else $error("write zero disturbed pending bit");

	irq_level_a: assert property (
		int_n_o == !(|state_reg.pending))
	else $error("interrupt output disagrees with pending bits");

	masked_no_set_a: assert property (
		((state_reg.pending & ~$past(state_reg.pending)) & ~$past(state_reg.enable)) == '0)
	else $error("pending bit set while disabled");

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	// the magnitude and signed compare need a sign bit plus one value bit
	generate
		if (POS_W < 2) begin : g_width_check
			$error("position width too small");
		end
	endgenerate

endmodule

// File: motion_event_pkg.sv
// constants shared by the motion event interrupt unit and its compare stage
package motion_event_pkg;

	// ----------------------------------------------------------------
	// register port geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int EVENT_COUNT = 8;

	// ----------------------------------------------------------------
	// register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] EVENT_ENABLE_ADDR = 7'h61;
	localparam logic [ADDR_W-1:0] EVENT_PENDING_ADDR = 7'h62;
	localparam logic [EVENT_COUNT-1:0] EVENT_ENABLE_RESET = 8'h00;
	localparam logic [EVENT_COUNT-1:0] EVENT_PENDING_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_DATA_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// bit positions inside both event registers
	// ----------------------------------------------------------------
	localparam int EV_TARGET = 0;
	localparam int EV_DEVIATION = 1;
	localparam int EV_INDEX = 2;
	localparam int EV_STOP = 3;
	localparam int EV_DRIVER = 4;
	localparam int EV_REF_LEFT = 5;
	localparam int EV_REF_RIGHT = 6;
	localparam int EV_COMPARE = 7;

	// ----------------------------------------------------------------
	// driver status readback fields
	// ----------------------------------------------------------------
	localparam int DRV_STATUS_W = 3;
	localparam int DRV_ERROR_BIT = 0;

endpackage

// File: compare_link_if.sv
// link between the event collector and the position compare stage
`timescale 1ns/1ps
interface compare_link_if #(
	parameter int POS_W = 32
);
	logic [POS_W-1:0] position; // selected position, two's complement
	logic [POS_W-1:0] compare_value;
	logic compare_wr; // one-cycle write of a new compare position
	logic out_level; // level of the compare output
	logic change; // one-cycle pulse on every output toggle

	modport ctl (
		output position,
		output compare_value,
		output compare_wr,
		input out_level,
		input change
	);

	modport unit (
		input position,
		input compare_value,
		input compare_wr,
		output out_level,
		output change
	);
endinterface

// File: position_compare_unit.sv
// position compare stage: drives the compare output and its change pulse
`timescale 1ns/1ps
module position_compare_unit
	import motion_event_pkg::*;
#(
	parameter int POS_W = 32
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// link to the event collector
	compare_link_if.unit link
);

	typedef struct packed {
		logic [POS_W-1:0] cmp; // compare position in use
		logic above; // last result of position > compare
		logic primed; // first result after reset taken
		logic level;
		logic change;
	} cmp_state_s;

	cmp_state_s state_reg;
	cmp_state_s state_next;
	logic above_now;

	// ----------------------------------------------------------------
	// compare and toggle
	// ----------------------------------------------------------------
	// one greater-than test serves both directions: moving right it turns
	// true at compare+1, moving left it turns false exactly at the match
	always_comb begin
		state_next = state_reg;
		state_next.change = 1'b0;
		if (link.compare_wr) begin
			state_next.cmp = link.compare_value;
		end
		above_now = $signed(link.position) > $signed(state_next.cmp);
		state_next.above = above_now;
		state_next.primed = 1'b1;
		// a new compare value toggles too when it flips the result
		if (state_reg.primed && (above_now != state_reg.above)) begin
			state_next.level = ~state_reg.level;
			state_next.change = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.out_level = state_reg.level;
	assign link.change = state_reg.change;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	move_right_hit_a: assert property (
		state_reg.primed && !link.compare_wr && !state_reg.above &&
		($signed(link.position) > $signed(state_reg.cmp))
		|=> link.change && (link.out_level != $past(link.out_level)))
	else $error("compare output missed position above compare");

	move_left_hit_a: assert property (
		state_reg.primed && !link.compare_wr && state_reg.above &&
		(link.position == state_reg.cmp)
		|=> link.change && !state_reg.above)
	else $error("compare output missed match while moving left");

	compare_write_a: assert property (
		state_reg.primed && link.compare_wr &&
		(($signed(link.position) > $signed(link.compare_value)) != state_reg.above)
		|=> link.change)
	else $error("compare write did not toggle output");

	generate
		if (POS_W < 2) begin : g_width_check
			$error("position width too small");
		end
	endgenerate

endmodule

// File: host_model.sv
// host side model: register writes and reads over the register port
`timescale 1ns/1ps
module host_model
	import motion_event_pkg::*;
(
	// clock
	input wire logic clock_i,
	// register port towards the device
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [ADDR_W-1:0] reg_addr_o,
	output logic [DATA_W-1:0] reg_wdata_o,
	input wire logic [DATA_W-1:0] reg_rdata_i
);
	// idle bus; address and data are scrambled while idle so stale values never pass
	initial begin
		reg_wr_o = 1'h0;
		reg_rd_o = 1'h0;
		reg_addr_o = 7'h00;
		reg_wdata_o = 32'h0;
	end

	// one-cycle write strobe; a one written to a pending bit clears it
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_i);
		reg_wr_o <= 1'h1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clock_i);
		reg_wr_o <= 1'h0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask

	// one-cycle read strobe, data taken once the answer edge has landed
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clock_i);
		reg_rd_o <= 1'h1;
		reg_addr_o <= a;
		@(posedge clock_i);
		reg_rd_o <= 1'h0;
		reg_addr_o <= ~a;
		@(negedge clock_i);
		d = reg_rdata_i;
	endtask
endmodule

// File: tb_motion_event_interrupt_unit.sv
// testbench for the motion event interrupt unit
`timescale 1ns/1ps
module tb_motion_event_interrupt_unit
	import motion_event_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clock_i, resetn_i, reg_wr, reg_rd, cmp_wr, cmp_out, int_n;
	logic target, index_ev, stop_ev, ref_l, ref_r, enc_sel;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [31:0] pid_err, pid_tol, x_act, enc_x, cmp_val, rdv;
	logic [2:0] drv_st;
	logic base;
	int err_count, cmp_count;

	// ----------------------------------------------------------------
	// device, host model and clock
	// ----------------------------------------------------------------
	motion_event_interrupt_unit #(.POS_W(32)) dut_u (
		.clock_i(clock_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.target_reached_i(target), .pid_error_i(pid_err), .pid_tolerance_i(pid_tol),
		.index_event_i(index_ev), .stop_event_i(stop_ev), .driver_status_i(drv_st),
		.ref_left_i(ref_l), .ref_right_i(ref_r), .x_actual_i(x_act), .enc_x_i(enc_x),
		.enc_select_i(enc_sel), .compare_value_i(cmp_val), .compare_wr_i(cmp_wr),
		.position_compare_out_o(cmp_out), .int_n_o(int_n));
	host_model host_u (.clock_i(clock_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

	// free running system clock
	initial begin
		clock_i = 1'h0;
		forever #20 clock_i = ~clock_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// bounded wait for the interrupt level; running out ends the run
	task automatic wait_int(input logic exp);
		int n;
		n = 0;
		while (int_n !== exp && n < 8) begin
			@(negedge clock_i);
			n++;
		end
		check("int_n_o", {31'h0, int_n}, {31'h0, exp});
		if (int_n !== exp) tally_and_finish();
	endtask

	task automatic rdp(input logic [7:0] exp);
		host_u.rd(EVENT_PENDING_ADDR, rdv);
		check("event_pending", rdv, {24'h0, exp});
	endtask

	// raise or drop one event source; driver status bits 2:1 stay high as a decoy
	task automatic drive(input int b, input logic v);
		@(posedge clock_i);
		case (b)
			0: target <= v;
			1: pid_err <= v ? 32'hFFFF_FFFB : 32'h0; // minus five, beyond tolerance
			2: index_ev <= v;
			3: stop_ev <= v;
			4: drv_st <= {2'h3, v};
			5: ref_l <= v;
			default: ref_r <= v;
		endcase
	endtask

	task automatic set_x(input logic [31:0] v);
		@(posedge clock_i);
		x_act <= v;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check("int_n_o", {31'h0, int_n}, 32'h1);
		rdp(8'h00);
		host_u.rd(EVENT_ENABLE_ADDR, rdv);
		check("event_enable read", rdv, 32'h0);
	endtask

	// every source except the compare change in turn sets only its own bit, then is cleared
	task automatic t_sources();
		host_u.wr(EVENT_ENABLE_ADDR, 32'hFFFF_FF7F);
		for (int b = 0; b < 7; b++) begin
			drive(b, 1'h1);
			wait_int(1'h0);
			drive(b, 1'h0);
			rdp(8'h01 << b);
			host_u.wr(EVENT_PENDING_ADDR, 32'h1 << b);
			wait_int(1'h1);
		end
	endtask

	// masked events are dropped; a one clears, a zero keeps
	task automatic t_mask();
		host_u.wr(EVENT_ENABLE_ADDR, 32'h0000_00F3);
		@(posedge clock_i);
		pid_err <= 32'hFFFF_FFFC; // minus four equals tolerance, strict test stays quiet
		drive(2, 1'h1);
		drive(3, 1'h1);
		drive(2, 1'h0);
		drive(3, 1'h0);
		rdp(8'h00);
		host_u.wr(EVENT_ENABLE_ADDR, 32'h0000_000C);
		drive(2, 1'h1);
		drive(3, 1'h1);
		drive(2, 1'h0);
		drive(3, 1'h0);
		host_u.wr(7'h63, 32'hFF); // unmapped, must change nothing
		rdp(8'h0C);
		host_u.wr(EVENT_PENDING_ADDR, 32'h04);
		rdp(8'h08);
		host_u.wr(EVENT_PENDING_ADDR, 32'h08);
		wait_int(1'h1);
	endtask

	// compare output: right move toggles at compare+1, left move at equality
	task automatic t_compare();
		host_u.wr(EVENT_ENABLE_ADDR, 32'h80);
		@(posedge clock_i);
		cmp_val <= 32'hA;
		cmp_wr <= 1'h1;
		@(posedge clock_i);
		cmp_wr <= 1'h0;
		repeat (4) @(posedge clock_i);
		host_u.wr(EVENT_PENDING_ADDR, 32'h80);
		wait_int(1'h1);
		base = cmp_out;
		set_x(32'hA);
		repeat (4) @(posedge clock_i);
		check("compare at equal, right", {31'h0, cmp_out}, {31'h0, base});
		set_x(32'hB);
		wait_int(1'h0);
		check("compare at plus one", {31'h0, cmp_out}, {31'h0, ~base});
		rdp(8'h80);
		host_u.wr(EVENT_PENDING_ADDR, 32'h80);
		set_x(32'hA);
		wait_int(1'h0);
		check("compare at equal, left", {31'h0, cmp_out}, {31'h0, base});
		host_u.wr(EVENT_PENDING_ADDR, 32'h80);
		@(posedge clock_i);
		cmp_val <= 32'h5;
		cmp_wr <= 1'h1;
		@(posedge clock_i);
		cmp_wr <= 1'h0;
		wait_int(1'h0);
		check("compare after write", {31'h0, cmp_out}, {31'h0, ~base});
		// encoder position selected: left move onto the compare value
		host_u.wr(EVENT_PENDING_ADDR, 32'h80);
		@(posedge clock_i);
		enc_x <= 32'h5;
		enc_sel <= 1'h1;
		wait_int(1'h0);
		check("compare on encoder", {31'h0, cmp_out}, {31'h0, base});
	endtask

	// reset in mid-run drops pending flags, enables and the compare output
	task automatic t_rearm();
		host_u.wr(EVENT_PENDING_ADDR, 32'h80);
		host_u.wr(EVENT_ENABLE_ADDR, 32'h08);
		wait_int(1'h1);
		drive(3, 1'h1);
		drive(3, 1'h0);
		wait_int(1'h0);
		@(posedge clock_i);
		resetn_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'h1;
		@(negedge clock_i);
		check("int_n_o after reset", {31'h0, int_n}, 32'h1);
		check("compare out after reset", {31'h0, cmp_out}, 32'h0);
		drive(3, 1'h1);
		drive(3, 1'h0);
		rdp(8'h00);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		cmp_count = 0;
		resetn_i = 1'h0;
		{target, index_ev, stop_ev, ref_l, ref_r, enc_sel, cmp_wr} = 7'h00;
		pid_err = 32'h0;
		pid_tol = 32'h4;
		x_act = 32'h0;
		enc_x = 32'h0;
		cmp_val = 32'h0;
		drv_st = 3'h6;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'h1;
		@(negedge clock_i);
		t_reset();
		t_sources();
		t_mask();
		t_compare();
		t_rearm();
		tally_and_finish();
	end
endmodule
